// ---- common/dic_pkg.sv ----
// Constants, register map and steps of the DDR init controller
package dic_pkg;

    // Clock rate and power-up wait
    localparam int CLK_MHZ    = 100;
    localparam int T_PWRUP_US = 200;
    localparam int PWRUP_CYC  = T_PWRUP_US * CLK_MHZ;

    // DLL settle time in memory clock cycles
    localparam int           DLL_CYC_INT = 200;
    localparam logic [7:0]   DLL_CYC     = 8'(DLL_CYC_INT);

    // Memory clock half period in hclk cycles
    localparam logic [2:0]   CK_HALF = 3'h4;

    // Register byte offsets
    localparam logic [7:0]   REG_CTRL   = 8'h00;
    localparam logic [7:0]   REG_MODE   = 8'h04;
    localparam logic [7:0]   REG_TIMING = 8'h08;
    localparam logic [7:0]   REG_STATUS = 8'h0C;

    // Control bits
    localparam int CTRL_START = 0;
    localparam int CTRL_DRV   = 1;
    localparam int CTRL_JCLR  = 2;
    localparam int CTRL_DLLR  = 3;

    // Timing field positions
    localparam int TIM_RP  = 0;
    localparam int TIM_MRD = 8;
    localparam int TIM_RFC = 16;

    // Status bit positions
    localparam int ST_BUSY  = 0;
    localparam int ST_DONE  = 1;
    localparam int ST_DLLOK = 2;
    localparam int ST_STEP  = 4;

    // Reset values
    localparam logic [12:0]  MODE_RST = 13'h0062;
    localparam logic [7:0]   TRP_RST  = 8'h03;
    localparam logic [7:0]   TMRD_RST = 8'h02;
    localparam logic [7:0]   TRFC_RST = 8'h02;

    // Mode register bits on the address lines
    localparam int DLL_DISABLE_BIT    = 0;
    localparam int DRIVE_STRENGTH_BIT = 1;
    localparam int DLL_RESET_BIT      = 8;
    localparam int PRE_ALL_BIT        = 10;

    // Bank select for the two mode registers
    localparam logic [1:0]   BA_MR  = 2'h0;
    localparam logic [1:0]   BA_EMR = 2'h1;

    // Command codes as {ras_n, cas_n, we_n}
    localparam logic [2:0]   CMD_NOP = 3'h7;
    localparam logic [2:0]   CMD_PRE = 3'h2;
    localparam logic [2:0]   CMD_LMR = 3'h0;
    localparam logic [2:0]   CMD_REF = 3'h1;

    // Chip selects: both ranks, or none
    localparam logic [1:0]   CS_ALL = 2'h0;
    localparam logic [1:0]   CS_OFF = 2'h3;

    // Initialization steps
    typedef enum logic [3:0] {
        S_IDLE, S_POWER, S_NOP, S_PRE1, S_EMR, S_MR, S_PRE2,
        S_REF1, S_REF2, S_MRC, S_READY, S_DLLR
    } dic_step_t;

endpackage

// ---- common/dic_reg_if.sv ----
// Register fields between bus slave and sequencer
`timescale 1ns/1ns
interface dic_reg_if;
    logic        start;
    logic        drv_reduced;
    logic        jedec_clear;
    logic        dll_req;
    logic [12:0] mode_val;
    logic [7:0]  t_rp;
    logic [7:0]  t_mrd;
    logic [7:0]  t_rfc;
    logic        busy;
    logic        done;
    logic        dll_ok;
    logic [3:0]  step;

    modport regs (output start, drv_reduced, jedec_clear, dll_req, mode_val,
                  output t_rp, t_mrd, t_rfc, input busy, done, dll_ok, step);
    modport core (input start, drv_reduced, jedec_clear, dll_req, mode_val,
                  input t_rp, t_mrd, t_rfc, output busy, done, dll_ok, step);
endinterface

// ---- hdl/dic_ahb_regs.sv ----
// AHB-Lite register slave of the DDR init controller
`timescale 1ns/1ns
module dic_ahb_regs (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Fields to the sequencer
    dic_reg_if.regs          rif
);
    logic        wr_q;
    logic        rd_q;
    logic [7:0]  addr_q;
    logic [31:0] rdata_q;
    logic [3:0]  ctrl_q;
    logic [12:0] mode_q;
    logic [23:0] tim_q;
    logic        acc;

    // NONSEQ or SEQ starts a transfer; hsize is ignored, every access is taken as a word
    assign acc = hsel && hready && htrans[1];

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q   <= 1'b0;
            rd_q   <= 1'b0;
            addr_q <= 8'h00;
        end
        else
        begin
            wr_q <= acc && hwrite;
            rd_q <= acc && !hwrite;
            if (acc)
                addr_q <= haddr[7:0];
        end
    end

    // Writes land in the data phase; pulses self-clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= 4'h0;
            mode_q <= dic_pkg::MODE_RST;
            tim_q  <= {dic_pkg::TRFC_RST, dic_pkg::TMRD_RST, dic_pkg::TRP_RST};
        end
        else
        begin
            ctrl_q[dic_pkg::CTRL_START] <= 1'b0;
            ctrl_q[dic_pkg::CTRL_DLLR]  <= 1'b0;
            if (wr_q && addr_q == dic_pkg::REG_CTRL)
                ctrl_q <= hwdata[3:0];
            if (wr_q && addr_q == dic_pkg::REG_MODE)
                mode_q <= hwdata[12:0];
            if (wr_q && addr_q == dic_pkg::REG_TIMING)
                tim_q <= hwdata[23:0];
        end
    end

    // One read wait state, so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= 32'h0000_0000;
        else if (rd_q)
        begin
            case (addr_q)
                dic_pkg::REG_CTRL:   rdata_q <= {28'h000_0000, ctrl_q};
                dic_pkg::REG_MODE:   rdata_q <= {19'h0_0000, mode_q};
                dic_pkg::REG_TIMING: rdata_q <= {8'h00, tim_q};
                dic_pkg::REG_STATUS: rdata_q <= {24'h00_0000, rif.step,
                                                 1'b0, rif.dll_ok, rif.done, rif.busy};
                default:             rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign hreadyout = !rd_q;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // Fields out to the sequencer
    assign rif.start       = ctrl_q[dic_pkg::CTRL_START];
    assign rif.drv_reduced = ctrl_q[dic_pkg::CTRL_DRV];
    assign rif.jedec_clear = ctrl_q[dic_pkg::CTRL_JCLR];
    assign rif.dll_req     = ctrl_q[dic_pkg::CTRL_DLLR];
    assign rif.mode_val    = mode_q;
    assign rif.t_rp        = tim_q[dic_pkg::TIM_RP +: 8];
    assign rif.t_mrd       = tim_q[dic_pkg::TIM_MRD +: 8];
    assign rif.t_rfc       = tim_q[dic_pkg::TIM_RFC +: 8];
endmodule

// ---- hdl/dic_init_ctrl.sv ----
// DDR power-up init controller, top level
//
// How it works
// - keep clock enable low after power-up
// - wait 200 us with clock enable low
// - raise clock enable, then one NOP first
// - precharge all, wait tRP, done twice
// - extended mode: DLL on, drive bit, rest zero
// - wait tMRD with NOPs after each mode load
// - then mode load with DLL reset set
// - 200 cycles from DLL reset to READ
// - two auto refreshes, each tRFC of NOPs
// - optional mode load clearing DLL reset bit
// - clock enable high throughout every refresh
// - frequency change: reset DLL, wait 200 cycles
`timescale 1ns/1ns
module dic_init_ctrl #(
    parameter int PWRUP_CYC = dic_pkg::PWRUP_CYC
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Memory clock
    output logic             ddr_ck,
    output logic             ddr_ck_n,
    // Memory command pins
    output logic             ddr_cke,
    output logic [1:0]       ddr_cs_n,
    output logic             ddr_ras_n,
    output logic             ddr_cas_n,
    output logic             ddr_we_n,
    output logic [1:0]       ddr_ba,
    output logic [12:0]      ddr_addr,
    // Normal traffic may start
    output logic             init_done
);
    dic_reg_if rif ();

    dic_pkg::dic_step_t step_q;
    logic [2:0]  div_q;
    logic        ck_q;
    logic        fall_tick;
    logic        div_end;
    logic [31:0] pwr_q;
    logic        pwr_end;
    logic [7:0]  wait_q;
    logic [7:0]  dll_q;
    logic        dll_kick;
    logic        cke_q;
    logic [1:0]  cs_q;
    logic [2:0]  cmd_q;
    logic [1:0]  ba_q;
    logic [12:0] addr_q;
    logic        dll_pend_q;

    // Register slave
    dic_ahb_regs u_regs (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .rif       (rif.regs)
    );

    // Wait after a command: field less one, floored at zero
    function automatic logic [7:0] gap(input logic [7:0] t);
        gap = (t == 8'h00) ? 8'h00 : t - 8'h01;
    endfunction

    // Mode word with DLL reset bit forced
    function automatic logic [12:0] mode_word(input logic [12:0] m, input logic rst);
        logic [12:0] w;
        w = m;
        w[dic_pkg::DLL_RESET_BIT] = rst;
        mode_word = w;
    endfunction

    // Memory clock divider, free running from reset so it is stable
    // long before the power-up wait ends
    assign div_end   = (div_q == dic_pkg::CK_HALF - 3'h1);
    assign fall_tick = div_end && ck_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q <= 3'h0;
            ck_q  <= 1'b0;
        end
        else if (div_end)
        begin
            div_q <= 3'h0;
            ck_q  <= !ck_q;
        end
        else
        begin
            div_q <= div_q + 3'h1;
        end
    end

    // Power-up wait counted in hclk cycles
    assign pwr_end = (pwr_q >= 32'(PWRUP_CYC));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pwr_q <= 32'h0000_0000;
        else if (step_q != dic_pkg::S_POWER)
            pwr_q <= 32'h0000_0000;
        else if (!pwr_end)
            pwr_q <= pwr_q + 32'h0000_0001;
    end

    // DLL settle counter, one count per memory clock,
    // restarted by each DLL-reset load
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dll_q <= 8'h00;
        else if (fall_tick && dll_kick)
            dll_q <= 8'h00;
        else if (fall_tick && dll_q != dic_pkg::DLL_CYC)
            dll_q <= dll_q + 8'h01;
    end

    assign dll_kick = (wait_q == 8'h00)
                   && (step_q == dic_pkg::S_MR || step_q == dic_pkg::S_DLLR);

    // Sequencer: pins change at the memory clock fall so
    // they are settled at the rise that takes them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            step_q <= dic_pkg::S_IDLE;
            wait_q <= 8'h00;
            cke_q  <= 1'b0;
            cs_q   <= dic_pkg::CS_OFF;
            cmd_q  <= dic_pkg::CMD_NOP;
            ba_q   <= 2'h0;
            addr_q <= 13'h0000;
        end
        else if (step_q == dic_pkg::S_IDLE)
        begin
            // Wait for software start
            if (rif.start)
                step_q <= dic_pkg::S_POWER;
        end
        else if (step_q == dic_pkg::S_POWER)
        begin
            // Clock enable low throughout
            if (pwr_end)
                step_q <= dic_pkg::S_NOP;
        end
        else if (fall_tick)
        begin
            // NOP to both ranks by default
            cs_q  <= dic_pkg::CS_ALL;
            cmd_q <= dic_pkg::CMD_NOP;
            if (wait_q != 8'h00)
            begin
                wait_q <= wait_q - 8'h01;
            end
            else
            begin
                case (step_q)
                    dic_pkg::S_NOP:
                    begin
                        // Clock enable rises with a NOP and stays
                        // high, covering every refresh
                        cke_q  <= 1'b1;
                        step_q <= dic_pkg::S_PRE1;
                    end
                    dic_pkg::S_PRE1:
                    begin
                        cmd_q  <= dic_pkg::CMD_PRE;
                        addr_q <= 13'h0000;
                        addr_q[dic_pkg::PRE_ALL_BIT] <= 1'b1;
                        wait_q <= gap(rif.t_rp);
                        step_q <= dic_pkg::S_EMR;
                    end
                    dic_pkg::S_EMR:
                    begin
                        // DLL on, drive strength from control
                        cmd_q  <= dic_pkg::CMD_LMR;
                        ba_q   <= dic_pkg::BA_EMR;
                        addr_q <= 13'h0000;
                        addr_q[dic_pkg::DLL_DISABLE_BIT]    <= 1'b0;
                        addr_q[dic_pkg::DRIVE_STRENGTH_BIT] <= rif.drv_reduced;
                        wait_q <= gap(rif.t_mrd);
                        step_q <= dic_pkg::S_MR;
                    end
                    dic_pkg::S_MR:
                    begin
                        cmd_q  <= dic_pkg::CMD_LMR;
                        ba_q   <= dic_pkg::BA_MR;
                        addr_q <= mode_word(rif.mode_val, 1'b1);
                        wait_q <= gap(rif.t_mrd);
                        step_q <= dic_pkg::S_PRE2;
                    end
                    dic_pkg::S_PRE2:
                    begin
                        cmd_q  <= dic_pkg::CMD_PRE;
                        addr_q <= 13'h0000;
                        addr_q[dic_pkg::PRE_ALL_BIT] <= 1'b1;
                        wait_q <= gap(rif.t_rp);
                        step_q <= dic_pkg::S_REF1;
                    end
                    dic_pkg::S_REF1:
                    begin
                        cmd_q  <= dic_pkg::CMD_REF;
                        wait_q <= gap(rif.t_rfc);
                        step_q <= dic_pkg::S_REF2;
                    end
                    dic_pkg::S_REF2:
                    begin
                        cmd_q  <= dic_pkg::CMD_REF;
                        wait_q <= gap(rif.t_rfc);
                        step_q <= rif.jedec_clear ? dic_pkg::S_MRC : dic_pkg::S_READY;
                    end
                    dic_pkg::S_MRC:
                    begin
                        // Same parameters, DLL reset cleared
                        cmd_q  <= dic_pkg::CMD_LMR;
                        ba_q   <= dic_pkg::BA_MR;
                        addr_q <= mode_word(rif.mode_val, 1'b0);
                        wait_q <= gap(rif.t_mrd);
                        step_q <= dic_pkg::S_READY;
                    end
                    dic_pkg::S_READY:
                    begin
                        // Only a clock change request leaves; banks
                        // stay idle as no traffic is issued here
                        if (dll_pend_q || rif.dll_req)
                            step_q <= dic_pkg::S_DLLR;
                    end
                    dic_pkg::S_DLLR:
                    begin
                        cmd_q  <= dic_pkg::CMD_LMR;
                        ba_q   <= dic_pkg::BA_MR;
                        addr_q <= mode_word(rif.mode_val, 1'b1);
                        wait_q <= gap(rif.t_mrd);
                        step_q <= dic_pkg::S_READY;
                    end
                    default:
                    begin
                        step_q <= dic_pkg::S_IDLE;
                    end
                endcase
            end
        end
    end

    // Holds a request arriving between clock ticks;
    // a one-cycle pulse would otherwise be lost
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dll_pend_q <= 1'b0;
        else if (rif.dll_req)
            dll_pend_q <= 1'b1;
        else if (step_q == dic_pkg::S_DLLR)
            dll_pend_q <= 1'b0;
    end

    // Ready after the last wait and the DLL settle
    // time; reads must not come earlier
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            init_done <= 1'b0;
        else
            init_done <= (step_q == dic_pkg::S_READY) && (wait_q == 8'h00)
                      && (dll_q == dic_pkg::DLL_CYC) && !dll_pend_q
                      && !rif.dll_req;
    end

    // Status to the slave
    assign rif.busy   = (step_q != dic_pkg::S_IDLE) && !init_done;
    assign rif.done   = init_done;
    assign rif.dll_ok = (dll_q == dic_pkg::DLL_CYC);
    assign rif.step   = step_q;

    // Pins straight from flip-flops, ddr_ck_n through an inverter
    assign ddr_ck    = ck_q;
    assign ddr_ck_n  = !ck_q;
    assign ddr_cke   = cke_q;
    assign ddr_cs_n  = cs_q;
    assign ddr_ras_n = cmd_q[2];
    assign ddr_cas_n = cmd_q[1];
    assign ddr_we_n  = cmd_q[0];
    assign ddr_ba    = ba_q;
    assign ddr_addr  = addr_q;
endmodule

// ---- bench/dic_init_ctrl_props.sv ----
// Concurrent checks on the init controller ports
`timescale 1ns/1ns
module dic_init_ctrl_props #(
    parameter int PWRUP_CYC = 50
) (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // AHB-Lite
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Memory pins
    input wire logic        ddr_ck,
    input wire logic        ddr_ck_n,
    input wire logic        ddr_cke,
    input wire logic [1:0]  ddr_cs_n,
    input wire logic        ddr_ras_n,
    input wire logic        ddr_cas_n,
    input wire logic        ddr_we_n,
    input wire logic [1:0]  ddr_ba,
    input wire logic [12:0] ddr_addr,
    input wire logic        init_done
);
    logic        ck_q;
    logic [31:0] low_cnt_q;
    logic [8:0]  dll_cnt_q;
    logic        taken;
    logic        cmd_slot;
    logic        lmr_dll;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Bus request and command slot
    assign taken = hsel && hready && htrans[1];
    assign cmd_slot = ddr_cs_n != dic_pkg::CS_OFF
        && {ddr_ras_n, ddr_cas_n, ddr_we_n} != dic_pkg::CMD_NOP;
    assign lmr_dll = cmd_slot && {ddr_ras_n, ddr_cas_n, ddr_we_n} == dic_pkg::CMD_LMR
        && ddr_ba == dic_pkg::BA_MR && ddr_addr[dic_pkg::DLL_RESET_BIT];

    // Cycles with clock enable low
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            low_cnt_q <= '0;
        else if (ddr_cke)
            low_cnt_q <= '0;
        else
            low_cnt_q <= low_cnt_q + 32'h0000_0001;

    // Memory clock rises since the last DLL-reset load, saturating
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            ck_q      <= 1'b0;
            dll_cnt_q <= '0;
        end
        else
        begin
            ck_q <= ddr_ck;
            if (ddr_ck && !ck_q && lmr_dll)
                dll_cnt_q <= '0;
            else if (ddr_ck && !ck_q && dll_cnt_q != 9'h1FF)
                dll_cnt_q <= dll_cnt_q + 9'h001;
        end

    ck_period_a: assert property ($rose(ddr_ck) |-> ddr_ck[*4] ##1 !ddr_ck[*4] ##1 ddr_ck)
        else $error("ck period");
    ck_pair_a: assert property (ddr_ck_n == !ddr_ck)
        else $error("ck pair not complementary");
    pwrup_wait_a: assert property ($rose(ddr_cke) |-> low_cnt_q >= PWRUP_CYC)
        else $error("cke rose early");
    cke_first_nop_a: assert property ($rose(ddr_cke) |-> !cmd_slot)
        else $error("cke rose with a command");
    cmd_needs_cke_a: assert property (cmd_slot |-> ddr_cke && $past(ddr_cke, 8))
        else $error("command with cke low");
    cke_hold_a: assert property (ddr_cke |=> ddr_cke)
        else $error("clock enable dropped");
    pin_timing_a: assert property
        ($changed({ddr_ba, ddr_addr, ddr_ras_n, ddr_cas_n, ddr_we_n}) |-> $fell(ddr_ck))
        else $error("pins moved off ck fall");
    dll_settle_a: assert property ($rose(init_done) |-> dll_cnt_q >= 9'd199)
        else $error("ready before DLL settled");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("bus response not OKAY");
    read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    write_nowait_a: assert property (taken && hwrite |=> hreadyout)
        else $error("write stalled");
endmodule

bind dic_init_ctrl dic_init_ctrl_props #(.PWRUP_CYC(PWRUP_CYC)) u_dic_init_ctrl_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .ddr_ck(ddr_ck),
    .ddr_ck_n(ddr_ck_n), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
    .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr),
    .init_done(init_done)
);

// ---- bench/dic_ddr_model.sv ----
// Memory module model: logs commands at each clock rise
`timescale 1ns/1ns
module dic_ddr_model (
    // Memory pins
    input wire logic        ddr_ck,
    input wire logic        ddr_cke,
    input wire logic [1:0]  ddr_cs_n,
    input wire logic        ddr_ras_n,
    input wire logic        ddr_cas_n,
    input wire logic        ddr_we_n,
    input wire logic [1:0]  ddr_ba,
    input wire logic [12:0] ddr_addr
);
    logic [2:0]  cmd_q [0:31];
    logic [14:0] loc_q [0:31];
    int          cyc_q [0:31];
    int          n_cmds = 0;
    int          ck_cnt = 0;
    int          cke_drops = 0;
    logic        cke_seen = 1'b0;

    // Commands register on the clock rise; no activates, so row time never arises
    always @(posedge ddr_ck)
    begin
        ck_cnt = ck_cnt + 1;
        if (cke_seen && !ddr_cke)
            cke_drops = cke_drops + 1;
        if (ddr_cke)
            cke_seen = 1'b1;
        if (ddr_cs_n != dic_pkg::CS_OFF && {ddr_ras_n, ddr_cas_n, ddr_we_n} != dic_pkg::CMD_NOP
            && n_cmds < 32)
        begin
            cmd_q[n_cmds] = {ddr_ras_n, ddr_cas_n, ddr_we_n};
            loc_q[n_cmds] = {ddr_ba, ddr_addr};
            cyc_q[n_cmds] = ck_cnt;
            n_cmds = n_cmds + 1;
        end
    end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the DDR init controller
`timescale 1ns/1ns
module tb;
    localparam int PWRUP = 50;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, init_done;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, ddr_cs_n, ddr_ba;
    logic [2:0]  hsize;
    logic        ddr_ck, ddr_ck_n, ddr_cke, ddr_ras_n, ddr_cas_n, ddr_we_n;
    logic [12:0] ddr_addr;
    int          mismatches = 0;
    int          num_checks = 0;

    // One slave: its ready is the bus ready
    assign hready = hreadyout;
    assign hsize  = 3'h2;

    dic_init_ctrl #(.PWRUP_CYC(PWRUP)) u_dic_init_ctrl (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ddr_ck(ddr_ck),
        .ddr_ck_n(ddr_ck_n), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
        .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr),
        .init_done(init_done)
    );

    dic_ddr_model u_dic_ddr_model (
        .ddr_ck(ddr_ck), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
        .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr)
    );

    // 100 MHz system clock
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One AHB single transfer
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0000_00, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0000_0000, d);
        chk(what, exp, d);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    task automatic wait_done(input logic lvl, input int lim);
        int k;
        k = 0;
        while (init_done !== lvl && k < lim)
        begin
            @(posedge hclk);
            k++;
        end
    endtask

    // Reset values; unmapped offset reads zero
    task automatic test_regs();
        logic [31:0] d;
        rd_chk("ctrl reset", dic_pkg::REG_CTRL, 32'h0000_0000);
        rd_chk("mode reset", dic_pkg::REG_MODE, 32'h0000_0062);
        rd_chk("timing reset", dic_pkg::REG_TIMING, 32'h0002_0203);
        rd_chk("status reset", dic_pkg::REG_STATUS, 32'h0000_0000);
        ahb(1'b1, 8'h10, 32'hFFFF_FFFF, d);
        rd_chk("unmapped", 8'h10, 32'h0000_0000);
        chk("cke low", 32'h0, ddr_cke);
    endtask

    // Full sequence, tRP 2, tMRD 3, tRFC 4
    task automatic run_init(input logic drv, input logic jclr);
        logic [31:0] d;
        logic [2:0]  ec [7];
        logic [14:0] ea [7];
        logic [14:0] em [7];
        int          eg [6];
        int          n0;
        int          c0, d0;
        n0 = u_dic_ddr_model.n_cmds;
        ec = '{3'h2, 3'h0, 3'h0, 3'h2, 3'h1, 3'h1, 3'h0};
        ea = '{15'h0400, {2'h1, 11'h000, drv, 1'b0}, 15'h0162, 15'h0400, 15'h0, 15'h0, 15'h0062};
        em = '{15'h0400, 15'h7FFF, 15'h7FFF, 15'h0400, 15'h0, 15'h0, 15'h7FFF};
        eg = '{2, 3, 3, 2, 4, 4};
        ahb(1'b1, dic_pkg::REG_TIMING, 32'h0004_0302, d);
        ahb(1'b1, dic_pkg::REG_CTRL, {29'h0, jclr, drv, 1'b1}, d);
        wait (ddr_cke === 1'b1);
        c0 = u_dic_ddr_model.ck_cnt;
        d0 = u_dic_ddr_model.cke_drops;
        wait_done(1'b1, 8000);
        chk("init done", 32'h1, init_done);
        chk("command count", jclr ? 7 : 6, u_dic_ddr_model.n_cmds - n0);
        chk("nop first", 32'h1, u_dic_ddr_model.cyc_q[n0] > c0 + 1);
        for (int i = 0; i < (jclr ? 7 : 6); i++)
        begin
            chk("command", ec[i], u_dic_ddr_model.cmd_q[n0 + i]);
            chk("fields", ea[i], u_dic_ddr_model.loc_q[n0 + i] & em[i]);
            if (i > 0)
                chk("spacing", 32'h1, u_dic_ddr_model.cyc_q[n0 + i]
                    - u_dic_ddr_model.cyc_q[n0 + i - 1] >= eg[i - 1]);
        end
        rd_chk("status ready", dic_pkg::REG_STATUS, 32'h0000_00A6);
        chk("cke stayed high", 32'h0, u_dic_ddr_model.cke_drops - d0);
    endtask

    // DLL reset after a clock change
    task automatic test_dll_reset();
        logic [31:0] d;
        int          n0;
        n0 = u_dic_ddr_model.n_cmds;
        ahb(1'b1, dic_pkg::REG_CTRL, 32'h0000_0008, d);
        wait_done(1'b0, 100);
        chk("ready drops", 32'h0, init_done);
        wait_done(1'b1, 4000);
        chk("ready again", 32'h1, init_done);
        chk("dll load", 32'h0162, u_dic_ddr_model.loc_q[n0]);
        chk("dll wait", 32'h1,
            u_dic_ddr_model.ck_cnt - u_dic_ddr_model.cyc_q[n0] >= 199);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (40000) @(posedge hclk);
        mismatches++;
        tally_and_finish();
    end

    // Main sequence; second reset lands after the DLL reset test, with the controller ready
    initial
    begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0000_0000;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hwdata  = 32'h0000_0000;
        @(posedge hclk);
        do_reset();
        test_regs();
        run_init(1'b1, 1'b1);
        test_dll_reset();
        do_reset();
        run_init(1'b0, 1'b0);
        tally_and_finish();
    end
endmodule
